// >>> dv/pesl_status_low_test.sv
`timescale 1ns/10ps

module pesl_status_low_test;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	pesl_pkg::pesl_bus_t busReq = '0;
	pesl_pkg::pesl_evt_t evt = '0;
	logic ringIndicateInN = 1'b1;
	logic thermalAlarmIn = 1'b1;
	logic [1:0] codecSerialDataIn = 2'b00;
	logic codecBitClock = 1'b0;
	logic sysAwake = 1'b1;
	logic bitClkRun = 1'b1;
	logic [1:0] bitClkDiv = 2'h0;
	logic [31:0] rdata;
	logic wakeEvent;
	logic sciOut;
	logic systemManagementInterruptN;
	logic irqOut;
	int errorCnt = 0;
	int checkCount = 0;
	int bitOf [6] = '{3, 4, 6, 5, 1, 7};

	// ==========================================================
	// Clock and device
	// ==========================================================
	always #4 sys_clk = ~sys_clk;

	// Bit clock slow enough to pass the pin filter
	always @(posedge sys_clk) begin
		if (bitClkRun) begin
			bitClkDiv <= bitClkDiv + 2'h1;
			if (bitClkDiv == 2'h3)
				codecBitClock <= ~codecBitClock;
		end
	end

	pesl_status_low dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.busReq(busReq),
		.evt(evt),
		.ringIndicateInN(ringIndicateInN),
		.thermalAlarmIn(thermalAlarmIn),
		.codecSerialDataIn(codecSerialDataIn),
		.codecBitClock(codecBitClock),
		.sysAwake(sysAwake),
		.rdata(rdata),
		.wakeEvent(wakeEvent),
		.sciOut(sciOut),
		.systemManagementInterruptN(systemManagementInterruptN),
		.irqOut(irqOut)
	);

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic endOfTest();
		if (errorCnt == 0 && checkCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		busReq.addr <= a;
		busReq.wdata <= d;
		busReq.wr <= 1'b1;
		@(posedge sys_clk);
		busReq.wr <= 1'b0;
	endtask

	task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		busReq.addr <= a;
		busReq.rd <= 1'b1;
		@(posedge sys_clk);
		busReq.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Event k for one cycle, wake pulse seen at the setting edge
	task automatic pulseEvt(input int k, output logic w);
		@(posedge sys_clk);
		case (k)
			0: evt.usbHost1Wake <= 1'b1;
			1: evt.usbHost2Wake <= 1'b1;
			2: evt.watchdogSci <= 1'b1;
			3: evt.codecGlobalSci <= 1'b1;
			4: evt.throttleActive <= 1'b1;
			default: begin
				evt.smbCmdValid <= 1'b1;
				evt.smbCmdCode <= pesl_pkg::SMB_WAKE_CMD;
			end
		endcase
		@(posedge sys_clk);
		evt <= '0;
		#1 w = wakeEvent;
	endtask

	task automatic waitSts(input logic [31:0] m, output logic [31:0] v);
		for (int n = 0; n < 150; n++) begin
			rdReg(pesl_pkg::OFS_STATUS, v);
			if ((v & m) !== 32'h0)
				break;
		end
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic testResetMap();
		logic [31:0] v;
		wrReg(8'h10, 32'hFFFFFFFF);
		wrReg(pesl_pkg::OFS_STATUS, 32'h0000FFFF);
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("status reset", 32'h0, v);
		for (int a = 4; a <= 16; a += 4) begin
			rdReg(8'(a), v);
			check("register reset", 32'h0, v);
		end
		check("smi idle", 32'h1, systemManagementInterruptN);
	endtask

	task automatic testEvents();
		logic [31:0] v;
		logic [31:0] m;
		logic w;
		for (int k = 0; k < 6; k++) begin
			m = 32'h1 << bitOf[k];
			pulseEvt(k, w);
			rdReg(pesl_pkg::OFS_STATUS, v);
			check("status set", m, v);
			cyc(1);
			check("rdata after read", 32'h0, rdata);
			wrReg(pesl_pkg::OFS_STATUS, ~m);
			rdReg(pesl_pkg::OFS_STATUS, v);
			check("status after zero write", m, v);
			wrReg(pesl_pkg::OFS_STATUS, m);
			rdReg(pesl_pkg::OFS_STATUS, v);
			check("status after clear", 32'h0, v);
		end
		@(posedge sys_clk);
		evt.smbCmdValid <= 1'b1;
		evt.smbCmdCode <= 8'h02;
		@(posedge sys_clk);
		evt <= '0;
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("other smbus code", 32'h0, v);
	endtask

	task automatic testWakeRoute();
		logic [31:0] v;
		logic w;
		wrReg(pesl_pkg::OFS_ENABLE, 32'h8);
		wrReg(pesl_pkg::OFS_CTRL, 32'h1);
		pulseEvt(0, w);
		check("wake enabled", 32'h1, w);
		cyc(1);
		check("wake pulse end", 32'h0, wakeEvent);
		check("sci routed", 32'h1, sciOut);
		wrReg(pesl_pkg::OFS_CTRL, 32'h0);
		cyc(2);
		check("sci off", 32'h0, sciOut);
		check("smi on", 32'h0, systemManagementInterruptN);
		@(posedge sys_clk);
		sysAwake <= 1'b0;
		cyc(3);
		check("smi asleep", 32'h1, systemManagementInterruptN);
		@(posedge sys_clk);
		sysAwake <= 1'b1;
		pulseEvt(1, w);
		check("wake disabled", 32'h0, w);
		wrReg(pesl_pkg::OFS_STATUS, 32'h1FB);
		wrReg(pesl_pkg::OFS_ENABLE, 32'h179);
		wrReg(pesl_pkg::OFS_CTRL, 32'h1);
		for (int k = 4; k < 6; k++) begin
			pulseEvt(k, w);
			check("silent wake", 32'h0, w);
			cyc(2);
			check("silent sci", 32'h0, sciOut);
		end
		wrReg(pesl_pkg::OFS_CTRL, 32'h0);
		cyc(2);
		check("silent smi", 32'h1, systemManagementInterruptN);
		wrReg(pesl_pkg::OFS_STATUS, 32'h1FB);
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("status cleared", 32'h0, v);
	endtask

	task automatic testThermal();
		logic [31:0] v;
		wrReg(pesl_pkg::OFS_ENABLE, 32'h1);
		wrReg(pesl_pkg::OFS_CTRL, 32'h1);
		thermalAlarmIn <= 1'b0;
		waitSts(32'h1, v);
		check("thermal low active", 32'h1, v);
		cyc(2);
		check("thermal sci", 32'h1, sciOut);
		@(posedge sys_clk);
		thermalAlarmIn <= 1'b1;
		cyc(8);
		wrReg(pesl_pkg::OFS_STATUS, 32'h1);
		cyc(4);
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("thermal high idle", 32'h0, v);
		wrReg(pesl_pkg::OFS_ENABLE, 32'h4);
		waitSts(32'h1, v);
		check("thermal high active", 32'h1, v);
		wrReg(pesl_pkg::OFS_ENABLE, 32'h0);
		wrReg(pesl_pkg::OFS_CTRL, 32'h0);
		wrReg(pesl_pkg::OFS_STATUS, 32'h1);
	endtask

	task automatic testRingIrq();
		logic [31:0] v;
		ringIndicateInN <= 1'b0;
		waitSts(32'h100, v);
		check("ring status", 32'h100, v);
		wrReg(pesl_pkg::OFS_IRQ_MASK, 32'h100);
		cyc(2);
		check("irq unmasked", 32'h1, irqOut);
		wrReg(pesl_pkg::OFS_IRQ_MASK, 32'h0);
		cyc(2);
		check("irq masked", 32'h0, irqOut);
		wrReg(pesl_pkg::OFS_IRQ_MASK, 32'h100);
		wrReg(pesl_pkg::OFS_STATUS, 32'h100);
		cyc(2);
		check("irq cleared", 32'h0, irqOut);
		@(posedge sys_clk);
		ringIndicateInN <= 1'b1;
	endtask

	task automatic testCodec();
		logic [31:0] v;
		codecSerialDataIn <= 2'b10;
		cyc(200);
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("codec clock running", 32'h0, v);
		bitClkRun <= 1'b0;
		waitSts(32'h20, v);
		check("codec clock stalled", 32'h20, v);
		@(posedge sys_clk);
		codecSerialDataIn <= 2'b00;
		bitClkRun <= 1'b1;
		cyc(8);
		wrReg(pesl_pkg::OFS_STATUS, 32'h20);
	endtask

	task automatic testSecondReset();
		logic [31:0] v;
		logic w;
		pulseEvt(0, w);
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("status before reset", 32'h8, v);
		@(posedge sys_clk);
		rst <= 1'b1;
		cyc(3);
		@(posedge sys_clk);
		rst <= 1'b0;
		rdReg(pesl_pkg::OFS_STATUS, v);
		check("status after reset", 32'h0, v);
	endtask

	// ==========================================================
	// Sequence and watchdog
	// ==========================================================
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		testResetMap();
		testEvents();
		testWakeRoute();
		testThermal();
		testRingIrq();
		testCodec();
		testSecondReset();
		endOfTest();
	end

	initial begin
		#400000;
		errorCnt++;
		endOfTest();
	end
endmodule

// >>> verilog/pesl_clk_watch.sv
`timescale 1ns/10ps

module pesl_clk_watch #(
	parameter int LIMIT = pesl_pkg::CODEC_BIT_CLOCK_STALL_CYC,
	parameter int CNT_W = 12
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkLevel,
	output logic stalled
);

	localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);
	localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

	logic prev;
	logic [CNT_W-1:0] cnt;

	// Any edge restarts the idle count
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev <= 1'b0;
			cnt <= '0;
			stalled <= 1'b0;
		end else begin
			prev <= clkLevel;
			if (clkLevel != prev) begin
				cnt <= '0;
				stalled <= 1'b0;
			end else if (cnt == LIMIT_C) begin
				stalled <= 1'b1;
			end else begin
				cnt <= cnt + ONE_C;
			end
		end
	end

endmodule

// >>> verilog/pesl_pkg.sv
package pesl_pkg;

	// ==========================================================
	// Bus and register map
	// ==========================================================
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;

	// ==========================================================
	// Status bit positions
	// ==========================================================
	localparam int BIT_RING = 8;
	localparam int BIT_SMB = 7;
	localparam int BIT_WDOG = 6;
	localparam int BIT_CODEC = 5;
	localparam int BIT_USB2 = 4;
	localparam int BIT_USB1 = 3;
	localparam int BIT_RSVD = 2;
	localparam int BIT_THROVR = 1;
	localparam int BIT_THRPIN = 0;

	// Enable register: polarity sits in the reserved status slot
	localparam int BIT_POL = 2;
	localparam int BIT_SCI_ROUTING_ENABLE = 0;

	// ==========================================================
	// Masks and reset values
	// ==========================================================
	localparam logic [REG_W-1:0] STS_IMPL = 16'h01FB;
	localparam logic [REG_W-1:0] EN_IMPL = 16'h017D;
	localparam logic [REG_W-1:0] SCI_SMI_MASK = 16'h0179;
	localparam logic [REG_W-1:0] WAKE_MASK = 16'h0139;
	localparam logic [REG_W-1:0] REG_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
	localparam logic [7:0] SMB_WAKE_CMD = 8'h01;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 8;
	localparam int CODEC_BIT_CLOCK_STALL_NS = 1000;
	localparam int CODEC_BIT_CLOCK_STALL_CYC =
		(CODEC_BIT_CLOCK_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Carriers
	// ==========================================================
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pesl_bus_t;

	typedef struct packed {
		logic smbCmdValid;
		logic [7:0] smbCmdCode;
		logic watchdogSci;
		logic codecGlobalSci;
		logic usbHost1Wake;
		logic usbHost2Wake;
		logic throttleActive;
	} pesl_evt_t;

endpackage

// >>> verilog/pesl_status_low.sv
// Notes on behaviour
// - Ring indicate going active sets status bit 8.
// - Status bits clear only on a written one; zero leaves them.
// - SMBus command 01h sets bit 7, even while awake.
// - Bit 7 never raises SCI or SMI by itself.
// - Watchdog logic causing an SCI sets bit 6.
// - Bit 5 set only by data-high with stalled bit clock, or global request.
// - Second USB host wake sets bit 4; wake only if enabled.
// - First USB host wake sets bit 3; wake only if enabled.
// - Thermal override starting throttle sets bit 1.
// - Thermal override bit never gives SMI, SCI or wake.
// - Thermal alarm pin asserted, per polarity, sets bit 0.
// - Thermal bit with its enable raises SCI or SMI.
// - Newly set status with enable set gives a wake event, except watchdog bit 6.
// - Awake: enabled event gives SCI if routed, else SMI.
// - Status cleared by resume-well reset only, not hard reset.
// - Polarity 0: low pin sets thermal bit; 1: high pin sets it.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps

module pesl_status_low (
	input wire logic sys_clk,
	input wire logic rst,
	input wire pesl_pkg::pesl_bus_t busReq,
	input wire pesl_pkg::pesl_evt_t evt,
	input wire logic ringIndicateInN,
	input wire logic thermalAlarmIn,
	input wire logic [1:0] codecSerialDataIn,
	input wire logic codecBitClock,
	input wire logic sysAwake,
	output logic [pesl_pkg::DATA_W-1:0] rdata,
	output logic wakeEvent,
	output logic sciOut,
	output logic systemManagementInterruptN,
	output logic irqOut
);

	localparam int RW = pesl_pkg::REG_W;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic ringLvl;
	logic thermLvl;
	logic bitClkLvl;
	logic [1:0] sdinLvl;
	logic bitClkStalled;

	pesl_sync #(.RST_VAL(1'b1)) u_ring_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pinIn(ringIndicateInN),
		.level(ringLvl)
	);

	pesl_sync #(.RST_VAL(1'b1)) u_therm_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pinIn(thermalAlarmIn),
		.level(thermLvl)
	);

	pesl_sync #(.RST_VAL(1'b0)) u_bclk_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pinIn(codecBitClock),
		.level(bitClkLvl)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sdin
			pesl_sync #(.RST_VAL(1'b0)) u_sdin_sync (
				.sys_clk(sys_clk),
				.rst(rst),
				.pinIn(codecSerialDataIn[gi]),
				.level(sdinLvl[gi])
			);
		end
	endgenerate

	pesl_clk_watch #(.LIMIT(pesl_pkg::CODEC_BIT_CLOCK_STALL_CYC)) u_bclk_watch (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkLevel(bitClkLvl),
		.stalled(bitClkStalled)
	);

	// ==========================================================
	// Registers
	// ==========================================================
	logic [RW-1:0] status;
	logic [RW-1:0] enable;
	logic [RW-1:0] irqMask;
	logic sciRouting;
	logic ringPrev;
	logic throtPrev;

	// ==========================================================
	// Event detection
	// ==========================================================
	wire ringActive = ~ringLvl;
	wire ringRise = ringActive & ~ringPrev;
	wire smbWake = evt.smbCmdValid &&
		(evt.smbCmdCode == pesl_pkg::SMB_WAKE_CMD);
	wire codecSet = (|sdinLvl & bitClkStalled) | evt.codecGlobalSci;
	wire throtRise = evt.throttleActive & ~throtPrev;
	wire thermPol = enable[pesl_pkg::BIT_POL];
	wire thermActive = (thermLvl == thermPol);

	logic [RW-1:0] setVec;
	always_comb begin
		setVec = '0;
		setVec[pesl_pkg::BIT_RING] = ringRise;
		setVec[pesl_pkg::BIT_SMB] = smbWake;
		setVec[pesl_pkg::BIT_WDOG] = evt.watchdogSci;
		setVec[pesl_pkg::BIT_CODEC] = codecSet;
		setVec[pesl_pkg::BIT_USB2] = evt.usbHost2Wake;
		setVec[pesl_pkg::BIT_USB1] = evt.usbHost1Wake;
		setVec[pesl_pkg::BIT_THROVR] = throtRise;
		setVec[pesl_pkg::BIT_THRPIN] = thermActive;
	end

	// ==========================================================
	// Bus decode
	// ==========================================================
	wire [RW-1:0] wdata16 = busReq.wdata[RW-1:0];
	wire selStatus = (busReq.addr == pesl_pkg::OFS_STATUS);
	wire selEnable = (busReq.addr == pesl_pkg::OFS_ENABLE);
	wire selCtrl = (busReq.addr == pesl_pkg::OFS_CTRL);
	wire selMask = (busReq.addr == pesl_pkg::OFS_IRQ_MASK);
	wire wrStatus = busReq.wr & selStatus;
	wire [RW-1:0] clrVec = wrStatus ? wdata16 : '0;

	// Set wins over a clear in the same cycle
	wire [RW-1:0] next_status =
		((status & ~clrVec) | setVec) & pesl_pkg::STS_IMPL;

	wire [RW-1:0] ctrlView = {{(RW-1){1'b0}}, sciRouting};
	wire [RW-1:0] readMux =
		selStatus ? status :
		selEnable ? enable :
		selCtrl ? ctrlView :
		selMask ? irqMask : '0;
	wire [pesl_pkg::DATA_W-1:0] next_rdata =
		busReq.rd ? {{(pesl_pkg::DATA_W-RW){1'b0}}, readMux} :
		pesl_pkg::DATA_ZERO;

	// ==========================================================
	// Event routing
	// ==========================================================
	wire [RW-1:0] newSet = setVec & ~status;
	wire next_wake =
		|(newSet & enable & pesl_pkg::WAKE_MASK);
	wire routePend =
		|(status & enable & pesl_pkg::SCI_SMI_MASK);
	wire next_sci = sysAwake & sciRouting & routePend;
	wire next_smi = sysAwake & ~sciRouting & routePend;
	wire next_irq = |(status & irqMask);

	// Only the resume-well reset clears status
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status <= pesl_pkg::REG_RST;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			enable <= pesl_pkg::REG_RST;
			irqMask <= pesl_pkg::REG_RST;
			sciRouting <= 1'b0;
		end else begin
			if (busReq.wr & selEnable) begin
				enable <= wdata16 & pesl_pkg::EN_IMPL;
			end
			if (busReq.wr & selMask) begin
				irqMask <= wdata16 & pesl_pkg::STS_IMPL;
			end
			if (busReq.wr & selCtrl) begin
				sciRouting <= busReq.wdata[pesl_pkg::BIT_SCI_ROUTING_ENABLE];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ringPrev <= 1'b0;
			throtPrev <= 1'b0;
			rdata <= pesl_pkg::DATA_ZERO;
			wakeEvent <= 1'b0;
			sciOut <= 1'b0;
			systemManagementInterruptN <= 1'b1;
			irqOut <= 1'b0;
		end else begin
			ringPrev <= ringActive;
			throtPrev <= evt.throttleActive;
			rdata <= next_rdata;
			wakeEvent <= next_wake;
			sciOut <= next_sci;
			systemManagementInterruptN <= ~next_smi;
			irqOut <= next_irq;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	chk_ring_sets: assert property (
		@(posedge sys_clk) disable iff (rst)
		ringRise |=> status[pesl_pkg::BIT_RING])
	else $error("ring indicate did not set status");

	chk_w1c_exact: assert property (
		@(posedge sys_clk) disable iff (rst)
		wrStatus |=> status == ((($past(status) & ~$past(wdata16))
			| $past(setVec)) & pesl_pkg::STS_IMPL))
	else $error("status write-one-clear wrong");

	chk_zero_keeps: assert property (
		@(posedge sys_clk) disable iff (rst)
		!wrStatus |=> ($past(status) & ~status) == '0)
	else $error("status bit lost without a write");

	chk_smb_sets: assert property (
		@(posedge sys_clk) disable iff (rst)
		smbWake |=> status[pesl_pkg::BIT_SMB])
	else $error("wake command did not set status");

	chk_smb_silent: assert property (
		@(posedge sys_clk) disable iff (rst)
		(status == (16'h0001 << pesl_pkg::BIT_SMB))
		|=> !sciOut && systemManagementInterruptN)
	else $error("smbus bit raised sci or smi");

	chk_wdog_sets: assert property (
		@(posedge sys_clk) disable iff (rst)
		evt.watchdogSci |=> status[pesl_pkg::BIT_WDOG])
	else $error("watchdog sci did not set status");

	chk_codec_only: assert property (
		@(posedge sys_clk) disable iff (rst)
		!codecSet && !status[pesl_pkg::BIT_CODEC]
		|=> !status[pesl_pkg::BIT_CODEC])
	else $error("codec bit set without cause");

	chk_codec_stall: assert property (
		@(posedge sys_clk) disable iff (rst)
		((|sdinLvl) && bitClkStalled) |=> status[pesl_pkg::BIT_CODEC])
	else $error("codec stall did not set status");

	chk_usb_sets: assert property (
		@(posedge sys_clk) disable iff (rst)
		evt.usbHost1Wake |=> status[pesl_pkg::BIT_USB1])
	else $error("usb host 1 wake did not set status");

	chk_usb2_sets: assert property (
		@(posedge sys_clk) disable iff (rst)
		evt.usbHost2Wake |=> status[pesl_pkg::BIT_USB2])
	else $error("usb host 2 wake did not set status");

	chk_usb_wake: assert property (
		@(posedge sys_clk) disable iff (rst)
		newSet[pesl_pkg::BIT_USB1] && enable[pesl_pkg::BIT_USB1]
		|=> wakeEvent)
	else $error("enabled usb wake gave no wake event");

	chk_throt_sets: assert property (
		@(posedge sys_clk) disable iff (rst)
		$rose(evt.throttleActive) |=> status[pesl_pkg::BIT_THROVR])
	else $error("throttle start did not set status");

	chk_ovr_silent: assert property (
		@(posedge sys_clk) disable iff (rst)
		(status == (16'h0001 << pesl_pkg::BIT_THROVR))
		&& ((setVec & ~(16'h0001 << pesl_pkg::BIT_THROVR)) == '0)
		|=> !wakeEvent && !sciOut && systemManagementInterruptN)
	else $error("override bit raised an event");

	chk_pin_polarity: assert property (
		@(posedge sys_clk) disable iff (rst)
		(thermLvl == enable[pesl_pkg::BIT_POL])
		|=> status[pesl_pkg::BIT_THRPIN])
	else $error("thermal pin did not set status");

	chk_therm_route: assert property (
		@(posedge sys_clk) disable iff (rst)
		status[pesl_pkg::BIT_THRPIN] && enable[pesl_pkg::BIT_THRPIN]
		&& sysAwake |=> (sciOut == $past(sciRouting))
		&& (systemManagementInterruptN == $past(sciRouting)))
	else $error("thermal event not routed");

	chk_sleep_quiet: assert property (
		@(posedge sys_clk) disable iff (rst)
		!sysAwake |=> !sciOut && systemManagementInterruptN)
	else $error("sci or smi while not awake");

	chk_rsvd_zero: assert property (
		@(posedge sys_clk) disable iff (rst)
		!status[pesl_pkg::BIT_RSVD] && !enable[1])
	else $error("reserved bit not zero");

	chk_reset_clear: assert property (
		@(posedge sys_clk)
		$fell(rst) |-> status == pesl_pkg::REG_RST)
	else $error("status not cleared by reset");

endmodule

// >>> verilog/pesl_sync.sv
`timescale 1ns/10ps

module pesl_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pinIn,
	output logic level
);

	logic q1;
	logic q2;
	logic q3;

	// Level moves only once the last two stages agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q1 <= RST_VAL;
			q2 <= RST_VAL;
			q3 <= RST_VAL;
			level <= RST_VAL;
		end else begin
			q1 <= pinIn;
			q2 <= q1;
			q3 <= q2;
			if (q2 == q3) begin
				level <= q3;
			end
		end
	end

endmodule
